// ==== nipc_pkg.sv ====
// Purpose: Constants for the nibble port control block
// Assumes: Registers are loaded by core instruction strobes, no bus
// Notes:   Reset values of port change enable and stop exit enable live here too
`default_nettype none
package nipc_pkg;
    localparam int          NIPC_W            = 4;
    localparam int          CFG_A_OPEN_DRAIN  = 0;
    localparam int          CFG_B_OPEN_DRAIN  = 1;
    localparam int          CFG_C_PULLUP      = 2;
    localparam logic [3:0]  CFG_RESET         = 4'h0;
    localparam logic [3:0]  DIR_RESET         = 4'hF;
    localparam logic [3:0]  STATUS_RESET      = 4'h0;
    localparam logic [3:0]  ENABLE_RESET      = 4'h0;
    localparam logic [3:0]  LED_RESET         = 4'hF;
    localparam int          HOLD_BIT_PORT_C   = 2;
    localparam int          INT_BIT_PORT_C    = 2;
endpackage
`default_nettype wire

// ==== nipc_sync3.sv ====
// Purpose: Three-stage synchroniser with agreement check, one per pin
// Assumes: sys_clk domain
// Notes:   Output changes only once stages two and three agree
`default_nettype none
module nipc_sync3
    import nipc_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic asyncIn,
    output var  logic syncOut
);
    logic stage1;
    logic stage2;
    logic stage3;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            stage1 <= 1'b1;
            stage2 <= 1'b1;
            stage3 <= 1'b1;
        end else begin
            stage1 <= asyncIn;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Pulled-up idle level so reset gives no false change
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            syncOut <= 1'b1;
        end else if (stage2 == stage3) begin
            syncOut <= stage3;
        end
    end
endmodule
`default_nettype wire

// ==== nibble_io_port_control.sv ====
// Purpose: GPIO port logic of a 4-bit core: ports A, B, D, input C, LED E
// Assumes: Core issues one-cycle write strobes with 4-bit data
// Notes:   Two-way pins split into in, out and active-low enable
`default_nettype none
module nibble_io_port_control
    import nipc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        cfgWrite,
    input  wire logic        dirAWrite,
    input  wire logic        dirBWrite,
    input  wire logic        dirDWrite,
    input  wire logic        changeEnWrite,
    input  wire logic        stopExitEnWrite,
    input  wire logic        portAWrite,
    input  wire logic        portBWrite,
    input  wire logic        portDWrite,
    input  wire logic        ledWrite,
    input  wire logic        statusClear,
    input  wire logic [3:0]  writeData,
    input  wire logic        holdReleaseEnPortC,
    input  wire logic        interruptEnPortC,
    input  wire logic        stopMode,
    input  wire logic [3:0]  portAIn,
    input  wire logic [3:0]  portBIn,
    input  wire logic [3:0]  portDIn,
    input  wire logic [3:0]  portCIn,
    input  wire logic [3:0]  stopFallLatched,
    output var  logic [3:0]  portAOut,
    output var  logic [3:0]  portAOe_n,
    output var  logic [3:0]  portBOut,
    output var  logic [3:0]  portBOe_n,
    output var  logic [3:0]  portDOut,
    output var  logic [3:0]  portDOe_n,
    output var  logic [3:0]  portAData,
    output var  logic [3:0]  portBData,
    output var  logic [3:0]  portDData,
    output var  logic [3:0]  portCPullUpEn,
    output var  logic [3:0]  ledOutputPort,
    output var  logic [3:0]  portCChangeStatus,
    output var  logic        portChangeEvent,
    output var  logic        holdReleaseReq,
    output var  logic        interruptReq,
    output var  logic        stopExitReq
);
    ////////////////////////////////////////////////////////////////////
    // Write-only mode registers; no readback path exists

    logic [3:0] portOutputConfig;
    logic [3:0] portADirection;
    logic [3:0] portBDirection;
    logic [3:0] portDDirection;
    logic [3:0] portChangeEnable;
    logic [3:0] stopExitEnable;
    logic [3:0] latchA;
    logic [3:0] latchB;
    logic [3:0] latchD;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            portOutputConfig <= CFG_RESET;
        end else if (cfgWrite) begin
            portOutputConfig <= writeData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            portADirection <= DIR_RESET;
            portBDirection <= DIR_RESET;
            portDDirection <= DIR_RESET;
        end else begin
            if (dirAWrite) begin
                portADirection <= writeData;
            end
            if (dirBWrite) begin
                portBDirection <= writeData;
            end
            if (dirDWrite) begin
                portDDirection <= writeData;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            portChangeEnable <= ENABLE_RESET;
            stopExitEnable   <= ENABLE_RESET;
        end else begin
            if (changeEnWrite) begin
                portChangeEnable <= writeData;
            end
            if (stopExitEnWrite) begin
                stopExitEnable <= writeData;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            latchA <= 4'h0;
            latchB <= 4'h0;
            latchD <= 4'h0;
        end else begin
            if (portAWrite) begin
                latchA <= writeData;
            end
            if (portBWrite) begin
                latchB <= writeData;
            end
            if (portDWrite) begin
                latchD <= writeData;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin drivers

    // Open drain only pulls low; a high bit releases the pin
    function automatic logic [3:0] pinEnableN(input logic [3:0] dir, input logic [3:0] data,
                                             input logic openDrain);
        pinEnableN = dir | ({4{openDrain}} & data);
    endfunction

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            portAOut  <= 4'h0;
            portBOut  <= 4'h0;
            portDOut  <= 4'h0;
            portAOe_n <= 4'hF;
            portBOe_n <= 4'hF;
            portDOe_n <= 4'hF;
        end else begin
            portAOut  <= latchA;
            portBOut  <= latchB;
            portDOut  <= latchD;
            portAOe_n <= pinEnableN(portADirection, latchA, portOutputConfig[CFG_A_OPEN_DRAIN]);
            portBOe_n <= pinEnableN(portBDirection, latchB, portOutputConfig[CFG_B_OPEN_DRAIN]);
            portDOe_n <= pinEnableN(portDDirection, latchD, 1'b0);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Input paths, three-stage synchronised

    logic [3:0] syncA;
    logic [3:0] syncB;
    logic [3:0] syncD;
    logic [3:0] syncC;
    // Pad edge latch is outside the clock domain as well
    logic [3:0] syncStop;

    genvar gi;
    generate
        for (gi = 0; gi < NIPC_W; gi++) begin : g_syncA
            nipc_sync3 nipc_sync3_inst (
                .sys_clk (sys_clk),
                .sys_rst (sys_rst),
                .asyncIn (portAIn[gi]),
                .syncOut (syncA[gi])
            );
        end
        for (gi = 0; gi < NIPC_W; gi++) begin : g_syncB
            nipc_sync3 nipc_sync3_inst (
                .sys_clk (sys_clk),
                .sys_rst (sys_rst),
                .asyncIn (portBIn[gi]),
                .syncOut (syncB[gi])
            );
        end
        for (gi = 0; gi < NIPC_W; gi++) begin : g_syncD
            nipc_sync3 nipc_sync3_inst (
                .sys_clk (sys_clk),
                .sys_rst (sys_rst),
                .asyncIn (portDIn[gi]),
                .syncOut (syncD[gi])
            );
        end
        for (gi = 0; gi < NIPC_W; gi++) begin : g_syncC
            nipc_sync3 nipc_sync3_inst (
                .sys_clk (sys_clk),
                .sys_rst (sys_rst),
                .asyncIn (portCIn[gi]),
                .syncOut (syncC[gi])
            );
        end
        // Reset level of one is harmless: stop exit enable resets to zero
        for (gi = 0; gi < NIPC_W; gi++) begin : g_syncStop
            nipc_sync3 nipc_sync3_inst (
                .sys_clk (sys_clk),
                .sys_rst (sys_rst),
                .asyncIn (stopFallLatched[gi]),
                .syncOut (syncStop[gi])
            );
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            portAData <= 4'h0;
            portBData <= 4'h0;
            portDData <= 4'h0;
        end else begin
            portAData <= syncA;
            portBData <= syncB;
            portDData <= syncD;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            portCPullUpEn <= 4'h0;
        end else begin
            portCPullUpEn <= {4{portOutputConfig[CFG_C_PULLUP]}};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Port C change detection

    logic [3:0] prevC;
    logic [3:0] changeC;
    logic       anyEnabledChange;

    always_comb begin
        changeC          = syncC ^ prevC;
        anyEnabledChange = |(changeC & portChangeEnable);
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            prevC <= 4'hF;
        end else begin
            prevC <= syncC;
        end
    end

    // A change in the clearing cycle survives the clear
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            portCChangeStatus <= STATUS_RESET;
        end else if (statusClear) begin
            portCChangeStatus <= changeC;
        end else begin
            portCChangeStatus <= portCChangeStatus | changeC;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            portChangeEvent <= 1'b0;
            holdReleaseReq  <= 1'b0;
            interruptReq    <= 1'b0;
        end else begin
            portChangeEvent <= anyEnabledChange;
            holdReleaseReq  <= anyEnabledChange && holdReleaseEnPortC;
            interruptReq    <= anyEnabledChange && interruptEnPortC;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Stop exit

    // Clock is stopped in stop mode; the pad-side latch catches the edge
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            stopExitReq <= 1'b0;
        end else begin
            stopExitReq <= stopMode && |(syncStop & stopExitEnable);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // LED port

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ledOutputPort <= LED_RESET;
        end else if (ledWrite) begin
            ledOutputPort <= writeData;
        end
    end
endmodule
`default_nettype wire

// ==== nipc_checker.sv ====
// Purpose: Port control assertions
// Assumes: Bound to the top module ports
// Notes:   Watches a subset of ports
`default_nettype none
module nipc_checker
    import nipc_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    input wire logic       cfgWrite,
    input wire logic       dirAWrite,
    input wire logic       stopExitEnWrite,
    input wire logic       ledWrite,
    input wire logic       statusClear,
    input wire logic [3:0] writeData,
    input wire logic       holdReleaseEnPortC,
    input wire logic [3:0] portAOut,
    input wire logic [3:0] portAOe_n,
    input wire logic [3:0] portCPullUpEn,
    input wire logic [3:0] ledOutputPort,
    input wire logic [3:0] portCChangeStatus,
    input wire logic       holdReleaseReq,
    input wire logic       stopExitReq
);
timeunit 1ns;
timeprecision 1ps;
default clocking @(posedge sys_clk); endclocking
default disable iff (sys_rst);
////////////////////////////////////////////////////////////////
a_reset_vals: assert property ($fell(sys_rst) |-> portAOe_n == DIR_RESET
    && ledOutputPort == LED_RESET && portCPullUpEn == 4'h0) else $error("reset values");
a_led_load: assert property (ledWrite |=> ledOutputPort == $past(writeData))
    else $error("led latch");
a_status_sticky: assert property (!statusClear |=>
    (portCChangeStatus & $past(portCChangeStatus)) == $past(portCChangeStatus)) else $error("status lost");
a_pullup_cfg: assert property (cfgWrite |-> ##2 portCPullUpEn == {4{$past(writeData[CFG_C_PULLUP], 2)}})
    else $error("pull-up");
a_drain_a: assert property (cfgWrite && writeData[0] ##1 !cfgWrite [*2] |->
    (portAOut & ~portAOe_n) == 4'h0) else $error("drain drives high");
a_dir_a: assert property (dirAWrite ##1 !dirAWrite [*2] |->
    (~portAOe_n & $past(writeData, 2)) == 4'h0) else $error("input pin driven");
a_hold_gate: assert property (!holdReleaseEnPortC ##1 !holdReleaseEnPortC |-> !holdReleaseReq)
    else $error("hold ungated");
a_stop_mask: assert property (stopExitEnWrite && writeData == 4'h0 ##1 !stopExitEnWrite [*3]
    |-> !stopExitReq) else $error("stop exit unmasked");
endmodule
`default_nettype wire

// ==== nipc_pin_model.sv ====
// Purpose: Board pins around the ports
// Assumes: Released pins show the board level
// Notes:   Switches drive port C both ways
`default_nettype none
module nipc_pin_model (
    input wire logic [3:0] portAOut,
    input wire logic [3:0] portAOe_n,
    input wire logic [3:0] portBOut,
    input wire logic [3:0] portBOe_n,
    input wire logic [3:0] portDOut,
    input wire logic [3:0] portDOe_n,
    input wire logic [3:0] extPins,
    input wire logic [3:0] extC,
    output logic     [3:0] portAIn,
    output logic     [3:0] portBIn,
    output logic     [3:0] portDIn,
    output logic     [3:0] portCIn
);
    timeunit 1ns;
    timeprecision 1ps;
    assign portAIn = (portAOut & ~portAOe_n) | (extPins & portAOe_n);
    assign portBIn = (portBOut & ~portBOe_n) | (extPins & portBOe_n);
    assign portDIn = (portDOut & ~portDOe_n) | (extPins & portDOe_n);
    assign portCIn = extC;
endmodule
`default_nettype wire

// ==== nibble_io_port_control_tb_top.sv ====
// Purpose: Self-checking bench
// Assumes: Inputs change at falling edge
// Notes:   Pin model stands in for the board
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module nibble_io_port_control_tb_top;
    import nipc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CFG = 0, DIRA = 1, DIRB = 2, DIRD = 3, CHEN = 4, SEN = 5, PA = 6, PB = 7, PD = 8, LED = 9, CLR = 10;
    logic        sys_clk = 1'b0, sys_rst = 1'b1, holdReleaseEnPortC = 1'b0, interruptEnPortC = 1'b0;
    logic        stopMode = 1'b0, evSeen, holdSeen, intSeen, stopSeen;
    logic [10:0] strb = 11'h000;
    logic [3:0]  writeData = 4'h0, stopFallLatched = 4'h0, extPins = 4'h0, extC = 4'hF;
    wire logic   cfgWrite, dirAWrite, dirBWrite, dirDWrite, changeEnWrite, stopExitEnWrite, portAWrite;
    wire logic   portBWrite, portDWrite, ledWrite, statusClear;
    wire logic   portChangeEvent, holdReleaseReq, interruptReq, stopExitReq;
    wire logic [3:0] portAIn, portBIn, portDIn, portCIn, portAOut, portAOe_n, portBOut, portBOe_n, portDOut;
    wire logic [3:0] portDOe_n, portAData, portBData, portDData, portCPullUpEn, ledOutputPort, portCChangeStatus;
    int          err_count = 0, checks_done = 0;
    assign {statusClear, ledWrite, portDWrite, portBWrite, portAWrite, stopExitEnWrite, changeEnWrite,
            dirDWrite, dirBWrite, dirAWrite, cfgWrite} = strb;
    always #5 sys_clk = ~sys_clk;
    nibble_io_port_control nibble_io_port_control_inst (.*);
    nipc_pin_model nipc_pin_model_inst (.*);
////////////////////////////////////////////////////////////////
    task automatic wr(input int sel, input logic [3:0] d);
        @(negedge sys_clk);
        strb = 11'h001 << sel;
        writeData = d;
    endtask
    // Pulses last one cycle, so sample every falling edge
    task automatic run(input int n);
        {evSeen, holdSeen, intSeen, stopSeen} = 4'h0;
        repeat (n) begin
            @(negedge sys_clk);
            strb = 11'h000;
            evSeen |= portChangeEvent;
            holdSeen |= holdReleaseReq;
            intSeen |= interruptReq;
            stopSeen |= stopExitReq;
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        print_verdict();
    end
////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(negedge sys_clk);
        sys_rst = 1'b0;
        run(2);
        `CHK("oeA", DIR_RESET, portAOe_n)
        `CHK("oeB", DIR_RESET, portBOe_n)
        `CHK("oeD", DIR_RESET, portDOe_n)
        `CHK("pullup", 4'h0, portCPullUpEn)
        `CHK("led", LED_RESET, ledOutputPort)
        wr(LED, 4'h5);
        wr(LED, 4'hA);
        `CHK("led1", 4'h5, ledOutputPort)
        run(1);
        `CHK("led2", 4'hA, ledOutputPort)
        wr(PA, 4'hA);
        wr(DIRA, 4'h0);
        run(3);
        `CHK("ppA", 4'h0, portAOe_n)
        `CHK("outA", 4'hA, portAOut)
        run(6);
        `CHK("readA", 4'hA, portAData)
        wr(CFG, 4'h1);
        run(3);
        `CHK("odA", 4'hA, portAOe_n)
        wr(PB, 4'h5);
        wr(DIRB, 4'h3);
        run(3);
        `CHK("ppB", 4'h3, portBOe_n)
        `CHK("outB", 4'h5, portBOut)
        wr(CFG, 4'h2);
        run(3);
        `CHK("odB", 4'h7, portBOe_n)
        `CHK("ppA2", 4'h0, portAOe_n)
        wr(PD, 4'h9);
        wr(DIRD, 4'h6);
        wr(CFG, 4'h3);
        extPins = 4'h6;
        run(3);
        `CHK("oeD2", 4'h6, portDOe_n)
        `CHK("outD", 4'h9, portDOut)
        run(6);
        `CHK("readD", 4'hF, portDData)
        `CHK("readB", 4'h6, portBData)
        wr(CFG, 4'h4);
        run(2);
        `CHK("pullup2", 4'hF, portCPullUpEn)
        wr(CHEN, 4'h2);
        holdReleaseEnPortC = 1'b1;
        interruptEnPortC = 1'b1;
        run(2);
        extC = 4'hD;
        run(8);
        `CHK("st1", 4'h2, portCChangeStatus)
        `CHK("ev1", 1'b1, evSeen)
        `CHK("hold1", 1'b1, holdSeen)
        `CHK("int1", 1'b1, intSeen)
        wr(CLR, 4'h0);
        run(2);
        `CHK("clr", 4'h0, portCChangeStatus)
        extC = 4'hC;
        run(8);
        `CHK("st2", 4'h1, portCChangeStatus)
        `CHK("ev2", 1'b0, evSeen)
        holdReleaseEnPortC = 1'b0;
        extC = 4'hE;
        run(8);
        `CHK("hold3", 1'b0, holdSeen)
        `CHK("int3", 1'b1, intSeen)
        holdReleaseEnPortC = 1'b1;
        interruptEnPortC = 1'b0;
        extC = 4'hC;
        run(8);
        `CHK("hold4", 1'b1, holdSeen)
        `CHK("int4", 1'b0, intSeen)
        wr(SEN, 4'h8);
        stopMode = 1'b1;
        stopFallLatched = 4'h1;
        run(4);
        `CHK("stop1", 1'b0, stopSeen)
        stopFallLatched = 4'h8;
        run(6);
        `CHK("stop2", 1'b1, stopSeen)
        wr(SEN, 4'h0);
        run(4);
        `CHK("stop3", 1'b0, stopExitReq)
        stopMode = 1'b0;
        sys_rst = 1'b1;
        run(2);
        sys_rst = 1'b0;
        run(2);
        `CHK("oeA3", DIR_RESET, portAOe_n)
        `CHK("oeB3", DIR_RESET, portBOe_n)
        `CHK("oeD3", DIR_RESET, portDOe_n)
        `CHK("pullup3", 4'h0, portCPullUpEn)
        `CHK("led3", LED_RESET, ledOutputPort)
        `CHK("st0", 4'h0, portCChangeStatus)
        print_verdict();
    end
endmodule
bind nibble_io_port_control nipc_checker nipc_checker_inst (.*);
`default_nettype wire
